// *** twrp_params.svh ***
// Timing and framing constants for the two-wire register port
`ifndef TWRP_PARAMS_SVH
`define TWRP_PARAMS_SVH
`define TWRP_CLK_PERIOD_NS     10
`define TWRP_ADDR_W            7
`define TWRP_DATA_W            8
`define TWRP_FRAME_BITS        16
`define TWRP_DIR_WRITE         1'h1
`define TWRP_DIR_READ          1'h0
`define TWRP_PREP_US           100
`define TWRP_PREP_CYC          ((`TWRP_PREP_US * 1000 + `TWRP_CLK_PERIOD_NS - 1) / `TWRP_CLK_PERIOD_NS)
`define TWRP_HOLD_NS           120
`define TWRP_HOLD_CYC          ((`TWRP_HOLD_NS + `TWRP_CLK_PERIOD_NS - 1) / `TWRP_CLK_PERIOD_NS)
`define TWRP_PD_US             100
`define TWRP_PD_CYC            ((`TWRP_PD_US * 1000 + `TWRP_CLK_PERIOD_NS - 1) / `TWRP_CLK_PERIOD_NS)
`define TWRP_TIMEOUT_MS        900
`define TWRP_TIMEOUT_CYC       ((`TWRP_TIMEOUT_MS * 1000000) / `TWRP_CLK_PERIOD_NS)
`define TWRP_SCLK_HALF_CYC     6
`endif

// *** twrp_pkg.sv ***
// Host state type for the two-wire register port, used by the host end only
package twrp_pkg;
  typedef enum logic [2:0] {
    TWRP_H_IDLE  = 3'b000,
    TWRP_H_ADDR  = 3'b001,
    TWRP_H_WAIT  = 3'b010,
    TWRP_H_DATA  = 3'b011,
    TWRP_H_HOLD  = 3'b100,
    TWRP_H_PD    = 3'b101
  } twrp_host_state_t;
endpackage

// *** twrp_if.sv ***
// Wire-level interface joining host and sensor ends
`timescale 1ns/100ps
interface twrp_if;
  logic sclk;
  logic power_down_line;
  logic sdio_host_out;
  logic sdio_host_oe;
  logic sdio_dev_out;
  logic sdio_dev_oe;
  logic sdio;
  // Pulled high when nobody drives; collision resolves to the device value
  assign sdio = sdio_dev_oe ? sdio_dev_out : (sdio_host_oe ? sdio_host_out : 1'b1);
  modport dev (
    input  sclk,
    input  power_down_line,
    input  sdio,
    output sdio_dev_out,
    output sdio_dev_oe
  );
  modport host (
    output sclk,
    output power_down_line,
    output sdio_host_out,
    output sdio_host_oe,
    input  sdio
  );
endinterface // twrp_if

// *** twrp_dev.sv ***
// Sensor end: serial slave giving access to a register store
//
// Overview of operation
// RULE1 - Only host starts transactions; device only responds
// RULE2 - Host makes the serial clock
// RULE3 - Write: address byte with MSB one, data
// RULE4 - Host changes on falling, device samples rising
// RULE5 - Read: address MSB zero, device returns data
// RULE6 - Host releases after address; device after data
// RULE7 - Host waits 100 us after read address
// RULE8 - Device holds last bit until next fall
// RULE9 - No transactions while power-down is high
// RULE10 - Power-down 100 us forces data pin Hi-Z
// RULE11 - After write, device data pin stays input
// RULE12 - Power-down pulse resynchronises the serial port
// RULE13 - Port resets if frame exceeds 0.9 s
// RULE14 - Unmapped writes ignored, unmapped reads zero
// RULE15 - Power-down resets port, keeps register contents
// RULE16 - Device drives after rising edge after fall
// RULE17 - MSB first, sixteen clocks per transaction
`timescale 1ns/100ps
`include "twrp_params.svh"
module twrp_dev #(
  parameter int TIMEOUT_CYC = `TWRP_TIMEOUT_CYC,
  parameter int PD_CYC      = `TWRP_PD_CYC
) (
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  twrp_if.dev                           link,
  output logic                          reg_wr_stb,
  output logic [`TWRP_ADDR_W-1:0]       reg_wr_addr,
  output logic [`TWRP_DATA_W-1:0]       reg_wr_data,
  output logic [`TWRP_ADDR_W-1:0]       reg_rd_addr,
  input  wire logic [`TWRP_DATA_W-1:0]  reg_rd_data,
  input  wire logic                     reg_rd_hit,
  output logic                          low_power
);
  logic [1:0]              sclk_sync;
  logic [1:0]              sdio_sync;
  logic [1:0]              pd_sync;
  logic                    sclk_q;
  logic                    sclk_rise;
  logic                    sclk_fall;
  logic [4:0]              bit_cnt;
  logic [14:0]             shift;
  logic                    is_read;
  logic [`TWRP_DATA_W-1:0] tx_byte;
  logic                    drive;
  logic                    last_bit;
  logic                    armed;
  logic [31:0]             tmo_cnt;
  logic [31:0]             pd_cnt;
  logic                    port_reset;
  logic                    tmo_hit;
  logic                    in_frame;

  // Sixteenth rising edge closes a frame
  function automatic logic frame_end(input logic [4:0] cnt);
    return cnt == 5'(`TWRP_FRAME_BITS - 1);
  endfunction

  // Two flip-flops on every pin before any logic reads it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_sync <= 2'h3;
      sdio_sync <= 2'h3;
      pd_sync   <= 2'h0;
    end else begin
      sclk_sync <= {sclk_sync[0], link.sclk};
      sdio_sync <= {sdio_sync[0], link.sdio};
      pd_sync   <= {pd_sync[0], link.power_down_line};
    end
  end

  // Seeded at the idle-high level so release of reset shows no edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'b1;
    end else begin
      sclk_q <= sclk_sync[1];
    end
  end

  assign sclk_rise = sclk_sync[1] & ~sclk_q;
  assign sclk_fall = ~sclk_sync[1] & sclk_q;

  // Power-down held long enough raises low_power only; the port reset does not wait for it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_cnt <= 32'h0;
    end else if (!pd_sync[1]) begin
      pd_cnt <= 32'h0;
    end else if (pd_cnt < PD_CYC) begin
      pd_cnt <= pd_cnt + 32'h1;
    end
  end

  // Low-power state only once the pulse has lasted its full width
  assign low_power  = (pd_cnt >= 32'(PD_CYC)); // [RULE12]

  assign tmo_hit    = (tmo_cnt >= TIMEOUT_CYC);
  // Port also idles during any power-down; shorter pulses still block edges [RULE9]
  assign port_reset = pd_sync[1] | tmo_hit; // [RULE10] [RULE12] [RULE15] [RULE13]

  // Transaction timer from first clock edge of a frame
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmo_cnt <= 32'h0;
    end else if (port_reset || (!in_frame && !sclk_fall && !sclk_rise)) begin
      tmo_cnt <= 32'h0;
    end else begin
      tmo_cnt <= tmo_cnt + 32'h1; // [RULE13]
    end
  end

  // Frame opens on its first clock edge, a fall, so the timer counts from there
  // Cleared after the sixteenth rise; a later fall opens the next frame
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_frame <= 1'b0;
    end else if (port_reset) begin
      in_frame <= 1'b0;
    end else if (sclk_rise && frame_end(bit_cnt)) begin
      in_frame <= 1'b0;
    end else if (sclk_fall || sclk_rise) begin
      in_frame <= 1'b1; // [RULE13]
    end
  end

  // Bit framing; responds only to host clock edges
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt <= 5'h0;
      shift   <= 15'h0;
      is_read <= 1'b0;
    end else if (port_reset) begin
      bit_cnt <= 5'h0; // [RULE15]
    end else if (sclk_rise) begin // [RULE1] [RULE4]
      shift <= {shift[13:0], sdio_sync[1]}; // [RULE17]
      if (bit_cnt == 5'h0) begin
        is_read <= (sdio_sync[1] == `TWRP_DIR_READ); // [RULE3] [RULE5]
      end
      if (frame_end(bit_cnt)) begin
        bit_cnt <= 5'h0; // [RULE17]
      end else begin
        bit_cnt <= bit_cnt + 5'h1;
      end
    end
  end

  // Address of a read; the store answers within the same cycle
  assign reg_rd_addr = shift[6:0];

  // Write commit on sixteenth rising edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_wr_stb  <= 1'b0;
      reg_wr_addr <= 7'h00;
      reg_wr_data <= 8'h00;
    end else begin
      reg_wr_stb <= 1'b0;
      if (!port_reset && sclk_rise && !is_read && frame_end(bit_cnt)) begin
        reg_wr_stb  <= 1'b1; // [RULE3] [RULE14]
        reg_wr_addr <= shift[13:7];
        reg_wr_data <= {shift[6:0], sdio_sync[1]};
      end
    end
  end

  // Read data output and turnaround
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_byte  <= 8'h00;
      drive    <= 1'b0;
      last_bit <= 1'b0;
      armed    <= 1'b0;
    end else if (port_reset) begin
      drive    <= 1'b0; // [RULE10]
      armed    <= 1'b0;
      last_bit <= 1'b0;
    end else begin
      // Address is whole only after its eighth rise; load at the turnaround fall
      if (sclk_fall && bit_cnt == 5'h8 && is_read) begin
        // Unmapped addresses answer zero
        tx_byte <= reg_rd_hit ? reg_rd_data : 8'h00; // [RULE14] [RULE7]
        armed   <= 1'b1;
      end
      if (sclk_rise && armed && bit_cnt == 5'h8) begin
        drive <= 1'b1; // [RULE16] [RULE5]
        armed <= 1'b0;
      // Next bit goes out on each later fall
      end else if (sclk_fall && drive && bit_cnt != 5'h8) begin
        tx_byte <= {tx_byte[6:0], 1'b0}; // [RULE17]
      end
      if (sclk_rise && drive && frame_end(bit_cnt)) begin
        last_bit <= 1'b1;
      end
      if (sclk_fall && last_bit) begin
        drive    <= 1'b0; // [RULE6] [RULE8]
        last_bit <= 1'b0;
      end
    end
  end

  // Writes never turn the pin around
  assign link.sdio_dev_oe  = drive; // [RULE11] [RULE2]
  assign link.sdio_dev_out = tx_byte[7];
endmodule // twrp_dev

// *** twrp_host.sv ***
// Host end: issues register reads and writes over the serial link
`timescale 1ns/100ps
`include "twrp_params.svh"
module twrp_host #(
  parameter int PREP_CYC = `TWRP_PREP_CYC,
  parameter int PD_CYC   = `TWRP_PD_CYC
) (
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  twrp_if.host                          link,
  input  wire logic                     req_valid,
  output logic                          req_ready,
  input  wire logic                     req_write,
  input  wire logic [`TWRP_ADDR_W-1:0]  req_addr,
  input  wire logic [`TWRP_DATA_W-1:0]  req_wdata,
  input  wire logic                     pd_req,
  output logic                          rsp_valid,
  output logic [`TWRP_DATA_W-1:0]       rsp_rdata
);
  twrp_pkg::twrp_host_state_t state;
  logic [15:0]  tx;
  logic [4:0]   nbit;
  logic [31:0]  tim;
  logic         phase;
  logic         wr;
  logic         sclk;
  logic         oe;
  logic         pd;
  logic [1:0]   sdio_sync;
  logic [`TWRP_DATA_W-1:0] rx;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sdio_sync <= 2'h3;
    end else begin
      sdio_sync <= {sdio_sync[0], link.sdio};
    end
  end

  assign req_ready = (state == twrp_pkg::TWRP_H_IDLE) && !pd_req; // [RULE1] [RULE9]

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= twrp_pkg::TWRP_H_IDLE;
      tx        <= 16'h0000;
      nbit      <= 5'h0;
      tim       <= 32'h0;
      phase     <= 1'b0;
      wr        <= 1'b0;
      sclk      <= 1'b1;
      oe        <= 1'b0;
      pd        <= 1'b0;
      rx        <= 8'h00;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      case (state)
        twrp_pkg::TWRP_H_IDLE: begin
          sclk <= 1'b1;
          if (pd_req) begin
            pd    <= 1'b1; // [RULE10] [RULE12]
            oe    <= 1'b0;
            tim   <= 32'h0;
            state <= twrp_pkg::TWRP_H_PD;
          end else if (req_valid) begin
            tx    <= {(req_write ? `TWRP_DIR_WRITE : `TWRP_DIR_READ), req_addr,
                      req_wdata}; // [RULE3] [RULE5]
            wr    <= req_write;
            nbit  <= 5'h0;
            tim   <= 32'h0;
            phase <= 1'b0;
            state <= twrp_pkg::TWRP_H_ADDR;
          end
        end
        twrp_pkg::TWRP_H_ADDR, twrp_pkg::TWRP_H_DATA: begin
          if (tim < `TWRP_SCLK_HALF_CYC - 1) begin
            tim <= tim + 32'h1;
          end else begin
            tim <= 32'h0;
            if (!phase) begin
              sclk <= 1'b0; // [RULE2] [RULE4]
              if (state == twrp_pkg::TWRP_H_ADDR || wr) begin
                oe <= 1'b1;
              end
              // Data moves only on falls; the first bit is already out
              if (nbit != 5'h0) begin
                tx <= {tx[14:0], 1'b0}; // [RULE4] [RULE17]
              end
              // Read bit taken late in the high phase, after the device drove it
              if (state == twrp_pkg::TWRP_H_DATA && !wr && nbit > 5'h8) begin
                rx <= {rx[6:0], sdio_sync[1]}; // [RULE5]
              end
              phase <= 1'b1;
            end else begin
              sclk  <= 1'b1;
              phase <= 1'b0;
              nbit  <= nbit + 5'h1;
              // Pin stays driven past the rise so the device samples the last bit
              if (nbit == 5'h7 && !wr) begin
                state <= twrp_pkg::TWRP_H_WAIT;
              end else if (nbit == 5'(`TWRP_FRAME_BITS - 1)) begin
                state <= twrp_pkg::TWRP_H_HOLD;
              end else if (nbit == 5'h7) begin
                state <= twrp_pkg::TWRP_H_DATA;
              end
            end
          end
        end
        twrp_pkg::TWRP_H_WAIT: begin
          if (tim < PREP_CYC - 1) begin
            tim <= tim + 32'h1; // [RULE7]
          end else begin
            tim   <= 32'h0;
            oe    <= 1'b0; // [RULE6]
            state <= twrp_pkg::TWRP_H_DATA;
          end
        end
        twrp_pkg::TWRP_H_HOLD: begin
          // Sample delay of sync stages covered by the hold wait
          if (tim < `TWRP_HOLD_CYC + 2) begin
            tim <= tim + 32'h1; // [RULE8]
          end else begin
            tim   <= 32'h0;
            oe    <= 1'b0;
            if (!wr) begin
              rsp_valid <= 1'b1;
              rsp_rdata <= {rx[6:0], sdio_sync[1]}; // [RULE8]
            end
            state <= twrp_pkg::TWRP_H_IDLE;
          end
        end
        twrp_pkg::TWRP_H_PD: begin
          if (tim < PD_CYC - 1) begin
            tim <= tim + 32'h1; // [RULE10]
          end else if (!pd_req) begin
            pd    <= 1'b0;
            tim   <= 32'h0;
            state <= twrp_pkg::TWRP_H_IDLE;
          end
        end
        default: begin
          state <= twrp_pkg::TWRP_H_IDLE;
        end
      endcase
    end
  end

  assign link.sclk            = sclk;
  assign link.power_down_line = pd;
  assign link.sdio_host_oe    = oe;
  assign link.sdio_host_out   = tx[15];
endmodule // twrp_host

// *** twrp_assertions.sv ***
// Wire-level checks on the link between host and sensor ends
`timescale 1ns/100ps
module twrp_assertions #(
  parameter int PREP_CYC = 20
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic power_down_line,
  input wire logic sdio_host_out,
  input wire logic sdio_host_oe,
  input wire logic sdio_dev_out,
  input wire logic sdio_dev_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic       sclk_d;
  logic [7:0] idle_cnt;
  // Cycles since sclk last moved, saturating
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d   <= 1'b1;
      idle_cnt <= 8'h00;
    end else begin
      sclk_d   <= sclk;
      idle_cnt <= (sclk != sclk_d) ? 8'h00 : ((idle_cnt == 8'hFF) ? idle_cnt : idle_cnt + 8'h01);
    end
  end
  AST_OVERLAP_LOW: assert property (
    sdio_host_oe && sdio_dev_oe |-> !sclk)
    else $error("both ends drive sdio while sclk high");
  AST_DEV_RELEASE: assert property (
    $fell(sclk) && sdio_host_oe |-> ##[0:12] !sdio_dev_oe)
    else $error("device kept sdio past hold time");
  AST_PD_HIZ: assert property (
    power_down_line [*8] |-> !sdio_dev_oe)
    else $error("device drives sdio during power-down");
  AST_DEV_START: assert property (
    $rose(sdio_dev_oe) |-> sclk && !sdio_host_oe && !power_down_line)
    else $error("device began driving at wrong moment");
  AST_HOST_FALL: assert property (
    sdio_host_oe && $past(sdio_host_oe) && $changed(sdio_host_out) |-> !sclk)
    else $error("host changed sdio while sclk high");
  AST_DEV_FALL: assert property (
    sdio_dev_oe && $past(sdio_dev_oe) && $changed(sdio_dev_out) |-> !sclk)
    else $error("device changed sdio while sclk high");
  AST_PD_QUIET: assert property (
    power_down_line && $past(power_down_line) |-> $stable(sclk))
    else $error("sclk moved during power-down");
  AST_PREP_WAIT: assert property (
    $fell(sclk) && !sdio_host_oe && !sdio_dev_oe |-> int'(idle_cnt) >= PREP_CYC - 2)
    else $error("read turnaround shorter than preparation time");
endmodule // twrp_assertions

// *** twrp_tb.sv ***
// Self-checking bench for host and sensor ends joined by the link
`timescale 1ns/100ps
module twrp_tb;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic [6:0]  req_addr = 7'h00;
  logic [7:0]  req_wdata = 8'h00;
  logic        pd_req = 1'b0;
  logic        req_ready, rsp_valid, reg_wr_stb, reg_rd_hit, low_power;
  logic [7:0]  rsp_rdata, reg_wr_data, reg_rd_data, addr_byte, q;
  logic [6:0]  reg_wr_addr, reg_rd_addr;
  logic [7:0]  regs [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
  logic [15:0] wire_bits;
  int          wire_cnt, failures, comparisons, cycles;
  twrp_if link ();
  twrp_host #(.PREP_CYC(20), .PD_CYC(20)) i_twrp_host (.ref_clk(ref_clk), .rst_n(rst_n),
    .link(link), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .pd_req(pd_req), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata));
  twrp_dev #(.TIMEOUT_CYC(2000), .PD_CYC(20)) i_twrp_dev (.ref_clk(ref_clk), .rst_n(rst_n),
    .link(link), .reg_wr_stb(reg_wr_stb), .reg_wr_addr(reg_wr_addr),
    .reg_wr_data(reg_wr_data), .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data),
    .reg_rd_hit(reg_rd_hit), .low_power(low_power));
  twrp_assertions #(.PREP_CYC(20)) i_twrp_assertions (.ref_clk(ref_clk), .rst_n(rst_n),
    .sclk(link.sclk), .power_down_line(link.power_down_line),
    .sdio_host_out(link.sdio_host_out), .sdio_host_oe(link.sdio_host_oe),
    .sdio_dev_out(link.sdio_dev_out), .sdio_dev_oe(link.sdio_dev_oe));
  // Miss data is junk so only the device can produce the zero byte
  assign reg_rd_hit  = (reg_rd_addr < 7'h04);
  assign reg_rd_data = reg_rd_hit ? regs[reg_rd_addr[1:0]] : 8'hA5;
  always @(posedge ref_clk) begin
    if (reg_wr_stb && reg_wr_addr < 7'h04) regs[reg_wr_addr[1:0]] <= reg_wr_data;
  end
  always @(posedge link.sclk) begin
    wire_bits = {wire_bits[14:0], link.sdio};
    wire_cnt  = wire_cnt + 1;
    if (wire_cnt == 8) addr_byte = wire_bits[7:0];
  end
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      end_sim();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic txn(input logic wr, input logic [6:0] a, input logic [7:0] d);
    int n;
    @(negedge ref_clk);
    wire_cnt  = 0;
    req_valid = 1'b1;
    req_write = wr;
    req_addr  = a;
    req_wdata = d;
    n = 0;
    while (req_ready !== 1'b1 && n < 1000) begin
      @(negedge ref_clk);
      n++;
    end
    chk(16'(n < 1000), 16'h0001);
    @(negedge ref_clk);
    req_valid = 1'b0;
    n = 0;
    while ((wr ? reg_wr_stb : rsp_valid) !== 1'b1 && n < 2000) begin
      @(negedge ref_clk);
      n++;
    end
    chk(16'(n < 2000), 16'h0001);
    q = rsp_rdata;
    chk({8'h00, addr_byte}, {8'h00, wr, a});
    chk(16'(wire_cnt), 16'h0010);
    if (wr) chk({reg_wr_addr, 1'b0, reg_wr_data}, {a, 1'b0, d});
  endtask
  task automatic t_rw();
    for (int i = 0; i < 4; i++) begin
      txn(1'b1, 7'(i), 8'h80 | 8'(i));
      txn(1'b0, 7'(i), 8'h00);
      chk({8'h00, q}, {8'h00, 8'h80 | 8'(i)});
    end
    txn(1'b1, 7'h03, 8'hFF);
    chk({15'h0000, link.sdio_dev_oe}, 16'h0000);
    txn(1'b1, 7'h03, 8'h3C);
    txn(1'b0, 7'h03, 8'h00);
    chk({8'h00, q}, 16'h003C);
    $display("Test read and write done");
  endtask
  task automatic t_unmapped();
    txn(1'b1, 7'h7F, 8'hFF);
    txn(1'b0, 7'h7F, 8'h00);
    chk({8'h00, q}, 16'h0000);
    txn(1'b0, 7'h04, 8'h00);
    chk({8'h00, q}, 16'h0000);
    txn(1'b0, 7'h03, 8'h00);
    chk({8'h00, q}, 16'h003C);
    $display("Test unmapped addresses done");
  endtask
  task automatic t_pd();
    txn(1'b0, 7'h00, 8'h00);
    repeat (20) @(negedge ref_clk);
    // Pull-up would read 1, so a held zero proves the device drives
    chk({14'h0000, link.sdio_dev_oe, link.sdio}, 16'h0002);
    pd_req = 1'b1;
    repeat (30) @(negedge ref_clk);
    chk({13'h0000, low_power, link.sdio_dev_oe, req_ready}, 16'h0004);
    pd_req = 1'b0;
    repeat (10) @(negedge ref_clk);
    chk({15'h0000, low_power}, 16'h0000);
    txn(1'b0, 7'h02, 8'h00);
    chk({8'h00, q}, 16'h0082);
    $display("Test power-down resync done");
  endtask
  task automatic end_sim();
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    t_rw();
    t_unmapped();
    t_pd();
    end_sim();
  end
endmodule // twrp_tb
